// [src/sdstp_top.sv]
/*
 Short-data text packer: packs characters MSB first into a bit-exact user
 data field, unpacks a received field, builds the time stamp element and
 its present flag, and drives the presentation cursor.
 Assumes the MAC side takes one bit per cycle when ready, the text source
 and the parser hold their inputs stable while a request is outstanding.
*/
`timescale 1ns/10ps
// Contract
// - A 7-bit character runs b7 to b1; characters pack with no gap.
// - The first character's b7 goes out first at the top position n.
// - No padding to an octet edge; the length is counted in bits.
// - 8-bit and 16-bit characters pack the same way, MSB first.
// - A 7-bit code uses b7..b5 as column and b4..b1 as row, values 0-127.
// - Line feed puts later characters on the next line, first position.
// - Carriage return restarts the current line at the first position.
// - Displayed characters fill left to right then top to bottom.
// - Time stamp is reserved 4, month 4, day 5, hour 5, minute 6 bits.
// - The reserved time stamp field is sent as 0000.
// - Month 1-12, day 1-31, hour 0-23 and minute 0-59 are encoded.
// - A one-bit flag says whether a time stamp follows (1) or not (0).
module sdstp_top (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Mode
   input wire sdstp_pkg::sdstp_cs_t cs_i,
   // Transmit character source
   input wire logic tx_vld_i,
   input wire logic [15:0] tx_char_i,
   output logic tx_rdy_o,
   // Transmit bit stream
   output logic tx_bit_vld_o,
   output logic tx_bit_o,
   input wire logic tx_bit_rdy_i,
   output logic [11:0] tx_len_o,
   input wire logic tx_len_clr_i,
   // Time stamp element
   input wire logic ts_req_i,
   input wire logic ts_use_i,
   input wire sdstp_pkg::sdstp_ts_t ts_i,
   output logic ts_flag_o,
   output logic [23:0] ts_field_o,
   output logic ts_err_o,
   // Receive bit stream
   input wire logic rx_bit_vld_i,
   input wire logic rx_bit_i,
   input wire logic rx_last_i,
   output logic rx_char_vld_o,
   output logic [15:0] rx_char_o,
   output logic [2:0] rx_col_o,
   output logic [3:0] rx_row_o,
   output logic [11:0] rx_count_o,
   output logic rx_done_o,
   // Presentation
   output logic put_vld_o,
   output sdstp_pkg::sdstp_disp_t put_o
);
   import sdstp_pkg::*;

   function automatic logic [4:0] cs_width(input sdstp_cs_t cs);
      case (cs)
         SDSTP_CS_7BIT: cs_width = SDSTP_W7;
         SDSTP_CS_8BIT: cs_width = SDSTP_W8;
         SDSTP_CS_16BIT: cs_width = SDSTP_W16;
         default: cs_width = SDSTP_W8;
      endcase
   endfunction

   logic [4:0] width;
   assign width = cs_width(cs_i);

   // Transmit shifter; the MAC stall holds the bit until taken
   logic [15:0] tsh_reg, tsh_next;
   logic [4:0] tcnt_reg, tcnt_next;
   logic tbusy_reg, tbusy_next;
   logic trdy_reg, trdy_next;
   logic tbit_reg, tbit_next;
   logic tbv_reg, tbv_next;
   logic [11:0] tlen_reg, tlen_next;

   always_comb begin
      tsh_next = tsh_reg;
      tcnt_next = tcnt_reg;
      tbusy_next = tbusy_reg;
      tbit_next = tbit_reg;
      tbv_next = tbv_reg;
      tlen_next = tx_len_clr_i ? 12'h000 : tlen_reg;
      if (tbv_reg && tx_bit_rdy_i) begin
         tbv_next = 1'b0;
         tlen_next = tlen_next + 12'h001;
      end
      if (!tbusy_reg && tx_vld_i && trdy_reg) begin
         // Left-justify so bit b7 (or the MSB) leaves first
         tsh_next = tx_char_i << (5'h10 - width);
         tcnt_next = width;
         tbusy_next = 1'b1;
      end else if (tbusy_reg && (!tbv_reg || tx_bit_rdy_i)) begin
         tbit_next = tsh_reg[15];
         tbv_next = 1'b1;
         tsh_next = {tsh_reg[14:0], 1'b0};
         tcnt_next = tcnt_reg - 5'h01;
         // No gap: next character may load right behind the last bit
         tbusy_next = (tcnt_reg != 5'h01);
      end
      trdy_next = !tbusy_next && !(!tbusy_reg && tx_vld_i && trdy_reg);
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tsh_reg <= 16'h0000;
         tcnt_reg <= 5'h00;
         tbusy_reg <= 1'b0;
         trdy_reg <= 1'b0;
         tbit_reg <= 1'b0;
         tbv_reg <= 1'b0;
         tlen_reg <= 12'h000;
      end else begin
         tsh_reg <= tsh_next;
         tcnt_reg <= tcnt_next;
         tbusy_reg <= tbusy_next;
         trdy_reg <= trdy_next;
         tbit_reg <= tbit_next;
         tbv_reg <= tbv_next;
         tlen_reg <= tlen_next;
      end
   end

   assign tx_rdy_o = trdy_reg;
   assign tx_bit_o = tbit_reg;
   assign tx_bit_vld_o = tbv_reg;
   assign tx_len_o = tlen_reg;

   // Time stamp element; out-of-range fields are flagged, not altered
   logic tsf_reg, tsf_next;
   logic [23:0] tsd_reg, tsd_next;
   logic tse_reg, tse_next;

   always_comb begin
      tsf_next = tsf_reg;
      tsd_next = tsd_reg;
      tse_next = tse_reg;
      if (ts_req_i) begin
         tsf_next = ts_use_i;
         tsd_next = ts_use_i ? {SDSTP_TS_RSV_DEFAULT, ts_i.month, ts_i.day,
            ts_i.hour, ts_i.minute} : 24'h000000;
         tse_next = ts_use_i && (ts_i.month < SDSTP_MONTH_MIN ||
            ts_i.month > SDSTP_MONTH_MAX || ts_i.day < SDSTP_DAY_MIN ||
            ts_i.day > SDSTP_DAY_MAX || ts_i.hour > SDSTP_HOUR_MAX ||
            ts_i.minute > SDSTP_MIN_MAX);
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tsf_reg <= 1'b0;
         tsd_reg <= 24'h000000;
         tse_reg <= 1'b0;
      end else begin
         tsf_reg <= tsf_next;
         tsd_reg <= tsd_next;
         tse_reg <= tse_next;
      end
   end

   assign ts_flag_o = tsf_reg;
   assign ts_field_o = tsd_reg;
   assign ts_err_o = tse_reg;

   // Receive shifter; a partial character at the end is dropped
   logic [15:0] rsh_reg, rsh_next;
   logic [4:0] rcnt_reg, rcnt_next;
   logic rcv_reg, rcv_next;
   logic [15:0] rch_reg, rch_next;
   logic [11:0] rnum_reg, rnum_next;
   logic rdone_reg, rdone_next;
   logic [15:0] shifted;

   always_comb begin
      rsh_next = rsh_reg;
      rcnt_next = rcnt_reg;
      rcv_next = 1'b0;
      rch_next = rch_reg;
      rnum_next = rdone_reg ? 12'h000 : rnum_reg;
      rdone_next = 1'b0;
      shifted = {rsh_reg[14:0], rx_bit_i};
      if (rx_bit_vld_i) begin
         rsh_next = shifted;
         if (rcnt_reg + 5'h01 == width) begin
            rcv_next = 1'b1;
            rch_next = shifted & ~(16'hFFFF << width);
            rnum_next = rnum_next + 12'h001;
            rcnt_next = 5'h00;
         end else begin
            rcnt_next = rcnt_reg + 5'h01;
         end
         if (rx_last_i) begin
            rcnt_next = 5'h00;
            rdone_next = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rsh_reg <= 16'h0000;
         rcnt_reg <= 5'h00;
         rcv_reg <= 1'b0;
         rch_reg <= 16'h0000;
         rnum_reg <= 12'h000;
         rdone_reg <= 1'b0;
      end else begin
         rsh_reg <= rsh_next;
         rcnt_reg <= rcnt_next;
         rcv_reg <= rcv_next;
         rch_reg <= rch_next;
         rnum_reg <= rnum_next;
         rdone_reg <= rdone_next;
      end
   end

   assign rx_char_vld_o = rcv_reg;
   assign rx_char_o = rch_reg;
   assign rx_col_o = rch_reg[6:4];
   assign rx_row_o = rch_reg[3:0];
   assign rx_count_o = rnum_reg;
   assign rx_done_o = rdone_reg;

   // Only the default alphabet has presentation control codes
   sdstp_disp u_disp (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .code_vld_i(rcv_reg && cs_i == SDSTP_CS_7BIT),
      .code_i(rch_reg[6:0]),
      .put_vld_o(put_vld_o),
      .put_o(put_o)
   );

   msb_first_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      !tbusy_reg && tx_vld_i && trdy_reg && cs_i == SDSTP_CS_7BIT
      ##1 (tbusy_reg && !tbv_reg) |=> tx_bit_o == $past(tx_char_i[6], 2))
      else $error("first bit is not b7");
   len_count_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      tbv_reg && tx_bit_rdy_i && !tx_len_clr_i |=>
      tx_len_o == $past(tx_len_o) + 12'h001)
      else $error("bit length not counted");
   ts_rsv_zero_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ts_field_o[23:20] == SDSTP_TS_RSV_DEFAULT)
      else $error("reserved stamp bits set");
   ts_layout_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ts_req_i && ts_use_i |=> ts_field_o[5:0] == $past(ts_i.minute) &&
      ts_field_o[19:16] == $past(ts_i.month))
      else $error("stamp field order wrong");
   ts_flag_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ts_req_i |=> ts_flag_o == $past(ts_use_i))
      else $error("stamp flag wrong");
   ts_range_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ts_req_i && ts_use_i && ts_i.hour > SDSTP_HOUR_MAX |=> ts_err_o)
      else $error("hour range not flagged");
   rx_tail_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      rx_bit_vld_i && rx_last_i && rcnt_reg + 5'h01 != width |=>
      !rx_char_vld_o) else $error("partial character emitted");
   rx_map_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      rx_char_vld_o && cs_i == SDSTP_CS_7BIT |->
      {rx_col_o, rx_row_o} == rx_char_o[6:0])
      else $error("column row split wrong");
endmodule // sdstp_top

// [src/sdstp_pkg.sv]
/*
 Package for the short-data text packer: character widths, time stamp
 layout, field ranges and the record types shared by the packer files.
 Assumes a single 100 MHz clock domain.
*/
package sdstp_pkg;
   // Character set selection
   typedef enum logic [1:0] {
      SDSTP_CS_7BIT,
      SDSTP_CS_8BIT,
      SDSTP_CS_16BIT
   } sdstp_cs_t;

   localparam logic [4:0] SDSTP_W7 = 5'h07;
   localparam logic [4:0] SDSTP_W8 = 5'h08;
   localparam logic [4:0] SDSTP_W16 = 5'h10;

   // Default alphabet control codes
   localparam logic [6:0] SDSTP_CODE_LF = 7'h0A;
   localparam logic [6:0] SDSTP_CODE_CR = 7'h0D;

   // Time stamp field layout, transmission order first
   localparam int SDSTP_TS_BITS = 24;
   localparam logic [3:0] SDSTP_TS_RSV_DEFAULT = 4'h0;
   localparam logic [3:0] SDSTP_MONTH_MIN = 4'h1;
   localparam logic [3:0] SDSTP_MONTH_MAX = 4'hC;
   localparam logic [4:0] SDSTP_DAY_MIN = 5'h01;
   localparam logic [4:0] SDSTP_DAY_MAX = 5'h1F;
   localparam logic [4:0] SDSTP_HOUR_MAX = 5'h17;
   localparam logic [5:0] SDSTP_MIN_MAX = 6'h3B;

   // Display geometry
   localparam logic [5:0] SDSTP_COLS = 6'h14;
   localparam logic [3:0] SDSTP_ROWS = 4'h8;

   typedef struct packed {
      logic [3:0] rsv;
      logic [3:0] month;
      logic [4:0] day;
      logic [4:0] hour;
      logic [5:0] minute;
   } sdstp_ts_t;

   typedef struct packed {
      logic [3:0] row;
      logic [5:0] col;
      logic [6:0] code;
   } sdstp_disp_t;
endpackage

// [src/sdstp_disp.sv]
/*
 Presentation cursor for 7-bit default-alphabet characters coming out of
 the unpacker. Assumes one code per strobe, synchronous to ref_clk_i.
*/
`timescale 1ns/10ps
module sdstp_disp (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Incoming codes
   input wire logic code_vld_i,
   input wire logic [6:0] code_i,
   // Placement
   output logic put_vld_o,
   output sdstp_pkg::sdstp_disp_t put_o
);
   import sdstp_pkg::*;

   logic [3:0] row_reg, row_next;
   logic [5:0] col_reg, col_next;
   logic put_vld_reg, put_vld_next;
   sdstp_disp_t put_reg, put_next;

   always_comb begin
      row_next = row_reg;
      col_next = col_reg;
      put_vld_next = 1'b0;
      put_next = put_reg;
      if (code_vld_i) begin
         if (code_i == SDSTP_CODE_LF) begin
            row_next = (row_reg == SDSTP_ROWS - 4'h1) ? 4'h0 :
               row_reg + 4'h1;
            col_next = 6'h00;
         end else if (code_i == SDSTP_CODE_CR) begin
            col_next = 6'h00;
         end else begin
            put_vld_next = 1'b1;
            put_next = '{row: row_reg, col: col_reg, code: code_i};
            if (col_reg == SDSTP_COLS - 6'h01) begin
               col_next = 6'h00;
               row_next = (row_reg == SDSTP_ROWS - 4'h1) ? 4'h0 :
                  row_reg + 4'h1;
            end else begin
               col_next = col_reg + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         row_reg <= 4'h0;
         col_reg <= 6'h00;
         put_vld_reg <= 1'b0;
         put_reg <= '0;
      end else begin
         row_reg <= row_next;
         col_reg <= col_next;
         put_vld_reg <= put_vld_next;
         put_reg <= put_next;
      end
   end

   assign put_vld_o = put_vld_reg;
   assign put_o = put_reg;

   lf_home_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      code_vld_i && code_i == SDSTP_CODE_LF |=> col_reg == 6'h00 &&
      !put_vld_o) else $error("line feed did not home cursor");
   cr_keep_row_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      code_vld_i && code_i == SDSTP_CODE_CR |=> col_reg == 6'h00 &&
      $stable(row_reg)) else $error("carriage return moved row");
   place_next_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      code_vld_i && code_i != SDSTP_CODE_LF && code_i != SDSTP_CODE_CR
      |=> put_vld_o && put_o.col == $past(col_reg))
      else $error("character not placed at cursor");
endmodule // sdstp_disp

// [tb/sdstp_mac_sink.sv]
/*
 MAC-side bit sink for the packer's transmit stream: takes offered bits,
 optionally stalling every other cycle. Assumes ref_clk_i and nrst_i of
 the packer, and that the bench pulses clr_i between messages.
*/
`timescale 1ns/10ps
module sdstp_mac_sink (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Control
   input wire logic slow_i,
   input wire logic clr_i,
   // Bit stream
   input wire logic bit_vld_i,
   input wire logic bit_i,
   output logic rdy_o,
   // Collected bits, newest at bit 0
   output logic [63:0] bits_o,
   output logic [7:0] n_o
);
   logic ph;
   initial begin
      rdy_o = 1'b0;
      ph = 1'b0;
   end
   // Slow mode holds each bit over a stall to test the hold
   always @(posedge ref_clk_i) begin
      ph <= #1 ~ph;
      rdy_o <= #1 nrst_i & (~slow_i | ph);
   end
   always @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bits_o <= 64'h0;
         n_o <= 8'h00;
      end else if (clr_i) begin
         bits_o <= 64'h0;
         n_o <= 8'h00;
      end else if (bit_vld_i && rdy_o) begin
         bits_o <= {bits_o[62:0], bit_i};
         n_o <= n_o + 8'h01;
      end
   end
endmodule // sdstp_mac_sink

// [tb/sds_text_packer_test.sv]
/*
 Self-checking bench for sdstp_top: packing, time stamp, unpacking and
 display placement. Assumes the MAC sink model beside it.
*/
`timescale 1ns/10ps
module sds_text_packer_test;
   import sdstp_pkg::*;
   logic ref_clk_i = 1'b0, nrst_i = 1'b0, tx_vld_i = 1'b0;
   logic tx_len_clr_i = 1'b0, ts_req_i = 1'b0, ts_use_i = 1'b0;
   logic rx_bit_vld_i = 1'b0, rx_bit_i = 1'b0, rx_last_i = 1'b0;
   logic slow = 1'b0, sclr = 1'b0, tx_rdy_o, tx_bit_vld_o, tx_bit_o;
   logic tx_bit_rdy_i, ts_flag_o, ts_err_o, rx_char_vld_o, rx_done_o;
   logic put_vld_o;
   logic [15:0] tx_char_i = 16'h0000, rx_char_o;
   logic [11:0] tx_len_o, rx_count_o, done_cnt;
   logic [23:0] ts_field_o;
   logic [2:0] rx_col_o;
   logic [3:0] rx_row_o;
   logic [63:0] sbits;
   logic [7:0] sn;
   sdstp_cs_t cs_i = SDSTP_CS_7BIT;
   sdstp_ts_t ts_i = '0;
   sdstp_disp_t put_o;
   logic [22:0] rx_q[$];
   logic [16:0] put_q[$];
   int bad_count = 0, compares = 0;
   sdstp_top dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cs_i(cs_i),
      .tx_vld_i(tx_vld_i), .tx_char_i(tx_char_i), .tx_rdy_o(tx_rdy_o),
      .tx_bit_vld_o(tx_bit_vld_o), .tx_bit_o(tx_bit_o),
      .tx_bit_rdy_i(tx_bit_rdy_i), .tx_len_o(tx_len_o),
      .tx_len_clr_i(tx_len_clr_i), .ts_req_i(ts_req_i), .ts_use_i(ts_use_i),
      .ts_i(ts_i), .ts_flag_o(ts_flag_o), .ts_field_o(ts_field_o),
      .ts_err_o(ts_err_o), .rx_bit_vld_i(rx_bit_vld_i), .rx_bit_i(rx_bit_i),
      .rx_last_i(rx_last_i), .rx_char_vld_o(rx_char_vld_o),
      .rx_char_o(rx_char_o), .rx_col_o(rx_col_o), .rx_row_o(rx_row_o),
      .rx_count_o(rx_count_o), .rx_done_o(rx_done_o),
      .put_vld_o(put_vld_o), .put_o(put_o));
   sdstp_mac_sink mac (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .slow_i(slow), .clr_i(sclr), .bit_vld_i(tx_bit_vld_o),
      .bit_i(tx_bit_o), .rdy_o(tx_bit_rdy_i), .bits_o(sbits), .n_o(sn));
   always #5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      if (rx_char_vld_o === 1'b1) rx_q.push_back({rx_col_o, rx_row_o,
         rx_char_o});
      if (put_vld_o === 1'b1) put_q.push_back(put_o);
      if (rx_done_o === 1'b1) done_cnt = rx_count_o;
   end
   task automatic end_sim;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // A wait loop that runs out is a failure, not a silent skip
   task automatic lim(input string nm, input int t, input int n);
      if (t >= n) begin
         bad_count++;
         $display("MISMATCH %s expected done seen timeout", nm);
      end
   endtask
   task automatic tick;
      @(posedge ref_clk_i);
      #1;
   endtask
   // Valid stays up between back-to-back chars; wait_bits drops it
   task automatic send(input logic [15:0] ch);
      int t = 0;
      tx_char_i = ch;
      tx_vld_i = 1'b1;
      while (tx_rdy_o !== 1'b1 && t < 300) begin
         tick();
         t++;
      end
      lim("tx_rdy_o", t, 300);
      tick();
   endtask
   task automatic start_msg(input sdstp_cs_t cs, input logic s);
      int t = 0;
      while (tx_bit_vld_o !== 1'b0 && t < 300) begin
         tick();
         t++;
      end
      lim("tx_bit_vld_o", t, 300);
      cs_i = cs;
      slow = s;
      sclr = 1'b1;
      tx_len_clr_i = 1'b1;
      tick();
      sclr = 1'b0;
      tx_len_clr_i = 1'b0;
   endtask
   task automatic wait_bits(input logic [7:0] n);
      int t = 0;
      tx_vld_i = 1'b0;
      while (sn !== n && t < 500) begin
         tick();
         t++;
      end
      lim("bit count", t, 500);
      tick();
   endtask
   task automatic t_pack7;
      logic [27:0] exp7 = {7'h41, 7'h2A, 7'h55, 7'h0F};
      start_msg(SDSTP_CS_7BIT, 1'b1);
      send(16'hFFC1);
      send(16'h002A);
      send(16'h0055);
      send(16'h000F);
      wait_bits(8'd28);
      chk("pack7 bits", 64'(exp7), sbits);
      chk("pack7 len", 64'd28, 64'(tx_len_o));
   endtask
   task automatic t_pack_wide;
      start_msg(SDSTP_CS_8BIT, 1'b0);
      send(16'hFFA5);
      send(16'h003C);
      wait_bits(8'd16);
      chk("pack8 bits", 64'h000000000000A53C, sbits);
      chk("pack8 len", 64'd16, 64'(tx_len_o));
      start_msg(SDSTP_CS_16BIT, 1'b1);
      send(16'hBEEF);
      wait_bits(8'd16);
      chk("pack16 bits", 64'h000000000000BEEF, sbits);
      chk("pack16 len", 64'd16, 64'(tx_len_o));
   endtask
   // Bench plays the switching infrastructure supplying the stamp
   task automatic t_ts(input logic u, input logic [3:0] m,
      input logic [4:0] d, h, input logic [5:0] mi, input logic er);
      logic [23:0] exp_ts;
      exp_ts = u ? {4'h0, m, d, h, mi} : 24'h000000;
      ts_i = '{4'h5, m, d, h, mi};
      ts_use_i = u;
      ts_req_i = 1'b1;
      tick();
      ts_req_i = 1'b0;
      tick();
      chk("ts flag", 64'(u), 64'(ts_flag_o));
      chk("ts field", 64'(exp_ts), 64'(ts_field_o));
      if (u) chk("ts err", 64'(er), 64'(ts_err_o));
   endtask
   task automatic rx_bits(input logic [15:0] v, input int w, input logic f);
      for (int i = w - 1; i >= 0; i--) begin
         rx_bit_vld_i = 1'b1;
         rx_bit_i = v[i];
         rx_last_i = f && i == 0;
         tick();
      end
   endtask
   task automatic t_rx_disp;
      logic [6:0] c[6] = '{7'h41, 7'h0A, 7'h42, 7'h44, 7'h0D, 7'h43};
      logic [16:0] p[4] = '{{4'h0, 6'h00, 7'h41}, {4'h1, 6'h00, 7'h42},
         {4'h1, 6'h01, 7'h44}, {4'h1, 6'h00, 7'h43}};
      cs_i = SDSTP_CS_7BIT;
      foreach (c[i]) rx_bits(16'(c[i]), 7, 1'b0);
      // Three tail bits shorter than a character
      rx_bits(16'h0005, 3, 1'b1);
      rx_bit_vld_i = 1'b0;
      rx_last_i = 1'b0;
      repeat (6) tick();
      chk("rx chars", 64'd6, 64'(rx_q.size()));
      chk("rx count", 64'd6, 64'(done_cnt));
      // Column b7..b5 and row b4..b1 together rebuild the code
      for (int i = 0; i < 6 && i < rx_q.size(); i++)
         chk("rx char", 64'({c[i], 9'h0, c[i]}), 64'(rx_q[i]));
      chk("puts", 64'd4, 64'(put_q.size()));
      for (int i = 0; i < 4 && i < put_q.size(); i++)
         chk("put", 64'(p[i]), 64'(put_q[i]));
      // Wide chars: whole char kept, short tail dropped, no display
      cs_i = SDSTP_CS_16BIT;
      rx_bits(16'hBEEF, 16, 1'b0);
      rx_bits(16'h0003, 2, 1'b1);
      rx_bit_vld_i = 1'b0;
      rx_last_i = 1'b0;
      repeat (4) tick();
      chk("rx16 count", 64'd1, 64'(done_cnt));
      chk("rx16 chars", 64'd7, 64'(rx_q.size()));
      chk("rx16 char", 64'hBEEF, 64'(rx_q[rx_q.size()-1][15:0]));
      chk("puts 16", 64'd4, 64'(put_q.size()));
   endtask
   initial begin
      #200000;
      bad_count++;
      end_sim();
   end
   initial begin
      repeat (5) @(posedge ref_clk_i);
      #1 nrst_i = 1'b1;
      tick();
      t_rx_disp();
      t_pack7();
      t_pack_wide();
      t_ts(1'b1, 4'hC, 5'h1F, 5'h17, 6'h3B, 1'b0);
      t_ts(1'b1, 4'hD, 5'h01, 5'h00, 6'h00, 1'b1);
      t_ts(1'b1, 4'h1, 5'h00, 5'h18, 6'h3C, 1'b1);
      t_ts(1'b0, 4'h3, 5'h02, 5'h04, 6'h05, 1'b0);
      end_sim();
   end
endmodule // sds_text_packer_test
